// ==== src/psw_pkg.sv ====
/*
 * Constants, field layout and command codes for the processor status word
 * block. Assumes a single synchronous CPU clock and that the execution unit
 * issues at most one status-word command per cycle.
 */
// Notes on behaviour
// - Bits 15-14 hold current mode: 00 kernel, 01 supervisor, 11 user.
// - Mode changes by status-word write, vector load, or stacked-status restore.
// - Vector entry fetches status in kernel space; previous mode gets old current mode.
// - Return restore may only set current-mode bits, never clear them.
// - Return restore may only set previous-mode bits, never clear them.
// - Previous mode selects the address space for cross-space moves.
// - Bit 11 selects which general register bank serves registers zero to five.
// - Bits 7-5 hold one of eight processor priority levels.
// - Bit 4 is the trace flag enabling the debugging trap.
// - Bits 3-0 hold condition codes of the last data operation.
// - On interrupt entry priority loads from the vector's status word, blocking equal or lower.
// - Accept interrupts above current priority; push context, load from vector.
// - Nested contexts resume last-in first-out through return-from-interrupt.
// - Requester supplies vector address; status read from kernel space there.
// - Status word is reachable by data transfer only in kernel space.
// - Mode change switches memory-management mapping to the new mode's set.
// - Software request register has one bit per level 1 to 7 and one fixed vector.
// - Software request register is writable only from kernel mode.
// - Set-priority takes one cycle and changes only the priority field.
// - Ordinary data writes leave the trace flag unchanged.
// - Data write to the status word loads condition codes with any value.
`default_nettype none
package psw_pkg;
    localparam int PSW_W = 16;
    localparam int CUR_HI = 15;
    localparam int CUR_LO = 14;
    localparam int PRV_HI = 13;
    localparam int PRV_LO = 12;
    localparam int RSET_B = 11;
    localparam int PRI_HI = 7;
    localparam int PRI_LO = 5;
    localparam int TRC_B = 4;
    localparam int CC_HI = 3;
    localparam int CC_LO = 0;
    localparam int LEVELS = 8;
    localparam logic [15:0] PSW_RESET = 16'h0000;
    localparam logic [15:0] PSW_USED_MASK = 16'hf8ff;
    localparam logic [15:0] SWI_VECTOR = 16'h00a0;
    localparam logic [15:0] SWI_USED_MASK = 16'hfe00;
    localparam logic [1:0] MODE_KERNEL = 2'h0;
    localparam logic [1:0] MODE_SUPER = 2'h1;
    localparam logic [1:0] MODE_USER = 2'h3;
    localparam logic [2:0] LVL_NONE = 3'h0;

    typedef enum logic [5:0] {
        PSW_CMD_NONE   = 6'h01,
        PSW_CMD_WRITE  = 6'h02,
        PSW_CMD_VECTOR = 6'h04,
        PSW_CMD_RETURN = 6'h08,
        PSW_CMD_SPL    = 6'h10,
        PSW_CMD_CC     = 6'h20
    } psw_cmd_t;
endpackage
`default_nettype wire

// ==== src/psw_if.sv ====
/*
 * Carrier between the status word core and the interrupt arbiter.
 * Assumes both ends share the CPU clock.
 */
`default_nettype none
interface psw_arb_if;
    logic [2:0] cur_pri;
    logic [7:0] swi_req;
    logic grant;
    logic [2:0] grant_lvl;
    logic grant_swi;
    logic [15:0] grant_vec;
    modport core (output cur_pri, output swi_req, input grant, input grant_lvl, input grant_swi, input grant_vec);
    modport arb (input cur_pri, input swi_req, output grant, output grant_lvl, output grant_swi, output grant_vec);
endinterface
`default_nettype wire

// ==== src/psw_arb.sv ====
/*
 * Priority arbiter: picks the highest pending level, device or software,
 * that lies above the processor priority. Assumes device requests are
 * synchronous levels with a vector per level.
 */
`default_nettype none
module psw_arb
    import psw_pkg::*;
#(
    parameter int N_LVL = LEVELS
) (
    psw_arb_if.arb bus,
    input wire logic [N_LVL-1:0] dev_req,
    input wire logic [N_LVL*16-1:0] dev_vec
);
    logic [N_LVL-1:0] any_req;
    logic [N_LVL-1:0] above;
    logic [2:0] best;
    logic found;
    genvar g;
    generate
        for (g = 0; g < N_LVL; g++) begin : g_lvl
            assign any_req[g] = dev_req[g] | bus.swi_req[g];
            assign above[g] = any_req[g] && (3'(g) > bus.cur_pri);
        end
    endgenerate
    always_comb begin
        best = LVL_NONE;
        found = 1'b0;
        for (int i = 0; i < N_LVL; i++) begin
            if (above[i]) begin
                best = 3'(i);
                found = 1'b1;
            end
        end
    end
    // Device requests win a tie since their handlers expect their own vector
    assign bus.grant = found;
    assign bus.grant_lvl = best;
    assign bus.grant_swi = found && !dev_req[best];
    assign bus.grant_vec = bus.grant_swi ? SWI_VECTOR : dev_vec[best*16 +: 16];
endmodule
`default_nettype wire

// ==== src/psw_swi.sv ====
/*
 * Software interrupt request register: one request bit per level 1..7.
 * Readback mirrors the highest pending level in bits 7-5 and 3-1.
 * Assumes kernel mode is qualified by the caller.
 */
`default_nettype none
module psw_swi
    import psw_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [15:0] wr_data,
    input wire logic clr_en,
    input wire logic [2:0] clr_lvl,
    output logic [7:0] req,
    output logic [15:0] rd_data
);
    logic [7:0] req_reg;
    logic [7:0] req_next;
    logic [2:0] top;
    always_comb begin
        req_next = req_reg;
        if (clr_en) begin
            req_next[clr_lvl] = 1'b0;
        end
        if (wr_en) begin
            req_next = {wr_data[15:9], 1'b0};
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            req_reg <= 8'h00;
        end else begin
            req_reg <= req_next;
        end
    end
    always_comb begin
        top = LVL_NONE;
        for (int i = 1; i < LEVELS; i++) begin
            if (req_reg[i]) begin
                top = 3'(i);
            end
        end
    end
    assign req = req_reg;
    assign rd_data = {req_reg[7:1], 1'b0, top, 1'b0, top, 1'b0};
endmodule
`default_nettype wire

// ==== src/psw_top.sv ====
/*
 * Processor status word logic: holds the status word, applies the
 * command issued by the execution unit, arbitrates interrupts and holds
 * the software request register. Assumes the execution unit sequences
 * stacking and vector fetches and reports results as commands.
 */
`default_nettype none
module psw_top
    import psw_pkg::*;
#(
    parameter int N_LVL = LEVELS
) (
    // Clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    // Command from the execution unit
    input wire logic [5:0] CMD_I,
    input wire logic [15:0] CMD_DATA_I,
    input wire logic [2:0] CMD_LVL_I,
    input wire logic [3:0] CC_I,
    input wire logic DATA_KERNEL_I,
    // Software request register access
    input wire logic SWI_WR_I,
    input wire logic [15:0] SWI_DATA_I,
    output logic [15:0] SWI_RD_O,
    // Interrupting devices
    input wire logic [N_LVL-1:0] DEV_REQ_I,
    input wire logic [N_LVL*16-1:0] DEV_VEC_I,
    input wire logic INT_ACK_I,
    output logic INT_PEND_O,
    output logic [2:0] INT_LVL_O,
    output logic [15:0] INT_VEC_O,
    output logic INT_SWI_O,
    // Status word and decoded fields
    output logic [15:0] PSW_O,
    output logic [1:0] CUR_MODE_O,
    output logic [1:0] PREV_MODE_O,
    output logic [1:0] MAP_SEL_O,
    output logic [1:0] XSPACE_MODE_O,
    output logic VEC_KERNEL_O,
    output logic REG_BANK_O,
    output logic [2:0] PRIORITY_O,
    output logic TRACE_O,
    output logic [3:0] CC_O,
    output logic MODE_CHANGED_O
);
    // ==========================================================
    // Command decode
    // ==========================================================
    psw_cmd_t cmd;
    logic [15:0] psw_reg;
    logic [15:0] psw_next;
    logic mode_chg_reg;
    logic is_kernel;
    logic wr_ok;
    logic do_write;
    logic do_vector;
    logic do_return;
    logic do_spl;
    logic do_cc;
    logic [15:0] wdat;

    assign cmd = psw_cmd_t'(CMD_I);
    assign is_kernel = psw_reg[CUR_HI:CUR_LO] == MODE_KERNEL;
    assign wr_ok = is_kernel && DATA_KERNEL_I;
    assign do_write = (cmd == PSW_CMD_WRITE) && wr_ok;
    assign do_vector = cmd == PSW_CMD_VECTOR;
    assign do_return = cmd == PSW_CMD_RETURN;
    assign do_spl = (cmd == PSW_CMD_SPL) && is_kernel;
    assign do_cc = cmd == PSW_CMD_CC;
    assign wdat = CMD_DATA_I & PSW_USED_MASK;

    // ==========================================================
    // Next status word
    // ==========================================================
    function automatic logic [15:0] psw_update(
        input logic [15:0] cur,
        input logic [15:0] d,
        input logic wr,
        input logic vec,
        input logic ret,
        input logic set_priority_instruction,
        input logic cc,
        input logic [2:0] lvl,
        input logic [3:0] ccv
    );
        logic [15:0] n;
        n = cur;
        if (vec) begin
            n = d;
            n[PRV_HI:PRV_LO] = cur[CUR_HI:CUR_LO];
        end else if (ret) begin
            n = d;
            n[CUR_HI:CUR_LO] = cur[CUR_HI:CUR_LO] | d[CUR_HI:CUR_LO];
            n[PRV_HI:PRV_LO] = cur[PRV_HI:PRV_LO] | d[PRV_HI:PRV_LO];
        end else if (wr) begin
            n = d;
            n[TRC_B] = cur[TRC_B];
        end else if (set_priority_instruction) begin
            n[PRI_HI:PRI_LO] = lvl;
        end else if (cc) begin
            n[CC_HI:CC_LO] = ccv;
        end
        return n & PSW_USED_MASK;
    endfunction

    assign psw_next = psw_update(psw_reg, wdat, do_write, do_vector, do_return,
                                 do_spl, do_cc, CMD_LVL_I, CC_I);

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            psw_reg <= PSW_RESET;
            mode_chg_reg <= 1'b0;
        end else begin
            psw_reg <= psw_next;
            mode_chg_reg <= psw_next[CUR_HI:CUR_LO] != psw_reg[CUR_HI:CUR_LO];
        end
    end

    // ==========================================================
    // Interrupt arbitration and software requests
    // ==========================================================
    psw_arb_if arb_bus ();
    logic swi_clr;

    assign arb_bus.cur_pri = psw_reg[PRI_HI:PRI_LO];
    // Honoring a software request retires its bit; a new kernel write still lands
    assign swi_clr = INT_ACK_I && arb_bus.grant && arb_bus.grant_swi;

    psw_arb #(
        .N_LVL(N_LVL)
    ) u_arb (
        .bus(arb_bus.arb),
        .dev_req(DEV_REQ_I),
        .dev_vec(DEV_VEC_I)
    );

    psw_swi u_swi (
        .clk(CLK_SYS_I),
        .rst(RST_I),
        .wr_en(SWI_WR_I && wr_ok),
        .wr_data(SWI_DATA_I),
        .clr_en(swi_clr),
        .clr_lvl(arb_bus.grant_lvl),
        .req(arb_bus.swi_req),
        .rd_data(SWI_RD_O)
    );

    // ==========================================================
    // Outputs
    // ==========================================================
    assign INT_PEND_O = arb_bus.grant;
    assign INT_LVL_O = arb_bus.grant_lvl;
    assign INT_VEC_O = arb_bus.grant_vec;
    assign INT_SWI_O = arb_bus.grant_swi;
    assign PSW_O = psw_reg;
    assign CUR_MODE_O = psw_reg[CUR_HI:CUR_LO];
    assign PREV_MODE_O = psw_reg[PRV_HI:PRV_LO];
    assign MAP_SEL_O = psw_reg[CUR_HI:CUR_LO];
    assign XSPACE_MODE_O = psw_reg[PRV_HI:PRV_LO];
    // Vector fetches always go through kernel mapping
    assign VEC_KERNEL_O = 1'b1;
    assign REG_BANK_O = psw_reg[RSET_B];
    assign PRIORITY_O = psw_reg[PRI_HI:PRI_LO];
    assign TRACE_O = psw_reg[TRC_B];
    assign CC_O = psw_reg[CC_HI:CC_LO];
    assign MODE_CHANGED_O = mode_chg_reg;
endmodule
`default_nettype wire

// ==== dv/psw_top_asserts.sv ====
/* Checker for the status word block, bound to psw_top.
   Assumes it sees the top module's ports only. */
`default_nettype none
module psw_top_asserts
    import psw_pkg::*;
#(parameter int N_LVL = LEVELS) (
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    input wire logic [5:0] CMD_I,
    input wire logic [15:0] CMD_DATA_I,
    input wire logic [2:0] CMD_LVL_I,
    input wire logic [3:0] CC_I,
    input wire logic DATA_KERNEL_I,
    input wire logic INT_PEND_O,
    input wire logic [2:0] INT_LVL_O,
    input wire logic [15:0] INT_VEC_O,
    input wire logic INT_SWI_O,
    input wire logic [15:0] PSW_O,
    input wire logic [1:0] CUR_MODE_O,
    input wire logic [1:0] XSPACE_MODE_O,
    input wire logic [2:0] PRIORITY_O,
    input wire logic MODE_CHANGED_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);
    wire logic kern = CUR_MODE_O == MODE_KERNEL;
    wire logic kern_wr = CMD_I == PSW_CMD_WRITE && kern && DATA_KERNEL_I;
    sequence s_vec;
        CMD_I == PSW_CMD_VECTOR;
    endsequence
    sequence s_ret;
        CMD_I == PSW_CMD_RETURN;
    endsequence
    property p_fields;
        CUR_MODE_O == PSW_O[15:14] && XSPACE_MODE_O == PSW_O[13:12] && PRIORITY_O == PSW_O[7:5];
    endproperty
    a_fields: assert property (p_fields) else $error("decoded field differs");
    property p_unused;
        PSW_O[10:8] == 3'h0;
    endproperty
    a_unused: assert property (p_unused) else $error("unused bits set");
    property p_vec;
        s_vec |=> PSW_O[13:12] == $past(PSW_O[15:14]) && PSW_O[15:14] == $past(CMD_DATA_I[15:14])
            && PSW_O[4:0] == $past(CMD_DATA_I[4:0]);
    endproperty
    a_vec: assert property (p_vec) else $error("vector load wrong");
    property p_ret;
        s_ret |=> PSW_O[15:12] == ($past(PSW_O[15:12]) | $past(CMD_DATA_I[15:12]));
    endproperty
    a_ret: assert property (p_ret) else $error("return cleared mode bits");
    property p_wr;
        kern_wr |=> PSW_O[4] == $past(PSW_O[4]) && PSW_O[3:0] == $past(CMD_DATA_I[3:0]);
    endproperty
    a_wr: assert property (p_wr) else $error("write trace or codes wrong");
    property p_refuse;
        CMD_I == PSW_CMD_WRITE && !DATA_KERNEL_I |=> $stable(PSW_O);
    endproperty
    a_refuse: assert property (p_refuse) else $error("non-kernel write took");
    property p_spl;
        CMD_I == PSW_CMD_SPL && kern |=> PRIORITY_O == $past(CMD_LVL_I)
            && {PSW_O[15:8], PSW_O[4:0]} == $past({PSW_O[15:8], PSW_O[4:0]});
    endproperty
    a_spl: assert property (p_spl) else $error("set priority wrong");
    property p_pend;
        INT_PEND_O |-> INT_LVL_O > PRIORITY_O;
    endproperty
    a_pend: assert property (p_pend) else $error("request at or below priority");
    property p_swi;
        INT_PEND_O && INT_SWI_O |-> INT_VEC_O == SWI_VECTOR;
    endproperty
    a_swi: assert property (p_swi) else $error("software vector wrong");
    property p_mchg;
        !$stable(CUR_MODE_O) |-> ##[0:1] MODE_CHANGED_O;
    endproperty
    a_mchg: assert property (p_mchg) else $error("mode change not flagged");
endmodule
bind psw_top psw_top_asserts #(.N_LVL(N_LVL)) u_chk (.CLK_SYS_I, .RST_I, .CMD_I, .CMD_DATA_I, .CMD_LVL_I,
    .CC_I, .DATA_KERNEL_I, .INT_PEND_O, .INT_LVL_O, .INT_VEC_O, .INT_SWI_O, .PSW_O, .CUR_MODE_O,
    .XSPACE_MODE_O, .PRIORITY_O, .MODE_CHANGED_O);
`default_nettype wire

// ==== dv/psw_dev_model.sv ====
/* Interrupting device model: one request per level, held until acknowledged.
   Assumes the ack carries the arbiter's level and software flag. */
`default_nettype none
module psw_dev_model #(
    parameter logic [15:0] VEC_BASE = 16'h0100
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] raise,
    input wire logic ack,
    input wire logic ack_swi,
    input wire logic [2:0] ack_lvl,
    output logic [7:0] req,
    output logic [127:0] vec
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic [7:0] drop = (ack && !ack_swi) ? 8'h01 << ack_lvl : 8'h00;
    always_ff @(posedge clk) begin
        if (rst)
            req <= 8'h00;
        else
            req <= (req | raise) & ~drop;
    end
    // Idle lines show the inverse so a stale vector cannot pass
    for (genvar i = 0; i < 8; i++) begin : g_vec
        assign vec[16*i+:16] = req[i] ? VEC_BASE + 16'(4*i) : ~(VEC_BASE + 16'(4*i));
    end
endmodule
`default_nettype wire

// ==== dv/processor_status_word_logic_bench.sv ====
/* Self-checking bench for psw_top with a device model.
   Assumes the package, interface and design are compiled first. */
`default_nettype none
module processor_status_word_logic_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import psw_pkg::*;
    logic clk = 1'b0, rst = 1'b1, dk = 1'b1, swi_wr = 1'b0, ack = 1'b0;
    logic [5:0] cmd = PSW_CMD_NONE;
    logic [15:0] cdata = 16'h0000, swi_data = 16'h0000, swi_rd, ivec, psw;
    logic [2:0] lvl = 3'h0, ilvl;
    logic [3:0] cc = 4'h0;
    logic [7:0] raise = 8'h00;
    logic pend, swi, mchg;
    logic [1:0] prev_m, map_sel;
    logic vec_k, rbank, trc;
    logic [3:0] cco;
    wire logic [7:0] dreq;
    wire logic [127:0] dvec;
    int error_cnt = 0, cmp_count = 0;
    initial forever #2 clk = ~clk;
    psw_top u_dut (.CLK_SYS_I(clk), .RST_I(rst), .CMD_I(cmd), .CMD_DATA_I(cdata), .CMD_LVL_I(lvl),
        .CC_I(cc), .DATA_KERNEL_I(dk), .SWI_WR_I(swi_wr), .SWI_DATA_I(swi_data), .SWI_RD_O(swi_rd),
        .DEV_REQ_I(dreq), .DEV_VEC_I(dvec), .INT_ACK_I(ack), .INT_PEND_O(pend), .INT_LVL_O(ilvl),
        .INT_VEC_O(ivec), .INT_SWI_O(swi), .PSW_O(psw), .CUR_MODE_O(), .PREV_MODE_O(prev_m),
        .MAP_SEL_O(map_sel), .XSPACE_MODE_O(), .VEC_KERNEL_O(vec_k), .REG_BANK_O(rbank), .PRIORITY_O(),
        .TRACE_O(trc), .CC_O(cco), .MODE_CHANGED_O(mchg));
    psw_dev_model u_dev (.clk(clk), .rst(rst), .raise(raise), .ack(ack), .ack_swi(swi), .ack_lvl(ilvl),
        .req(dreq), .vec(dvec));
    // ==========================================
    // Shared drivers and compare
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic issue(input logic [5:0] c, input logic [15:0] d, input logic [2:0] l);
        @(posedge clk);
        cmd <= c;
        cdata <= d;
        lvl <= l;
        cc <= d[3:0];
        @(posedge clk);
        cmd <= PSW_CMD_NONE;
        #1;
    endtask
    task automatic pulse(input logic [15:0] sd, input logic [7:0] r, input logic a);
        @(posedge clk);
        swi_wr <= |sd;
        swi_data <= sd;
        raise <= r;
        ack <= a;
        @(posedge clk);
        swi_wr <= 1'b0;
        raise <= 8'h00;
        ack <= 1'b0;
        #1;
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ==========================================
    // Scenarios
    task automatic t_write;
        chk("reset", 16'h0000, psw);
        issue(PSW_CMD_WRITE, 16'h0ffa, 3'h0);
        chk("write", 16'h08ea, psw);
        chk("bank", 16'h0001, rbank);
        chk("trace_kept", 16'h0000, trc);
        chk("cc_wr", 16'h000a, cco);
        issue(PSW_CMD_SPL, 16'h0000, 3'h5);
        chk("spl", 16'h08aa, psw);
        issue(PSW_CMD_CC, 16'h0005, 3'h0);
        chk("cc", 16'h08a5, psw);
        chk("cc_o", 16'h0005, cco);
        $display("test write done");
    endtask
    task automatic t_modes;
        issue(PSW_CMD_VECTOR, 16'hc010, 3'h0);
        chk("vector", 16'hc010, psw);
        chk("trace", 16'h0001, trc);
        chk("map", 16'h0003, map_sel);
        chk("vec_kern", 16'h0001, vec_k);
        // The mode-change flag is registered alongside the status word
        chk("modechg", 16'h0001, mchg);
        @(posedge clk);
        #1;
        chk("modechg_end", 16'h0000, mchg);
        issue(PSW_CMD_WRITE, 16'h0000, 3'h0);
        issue(PSW_CMD_SPL, 16'h0000, 3'h7);
        chk("user", 16'hc010, psw);
        pulse(16'hfe00, 8'h00, 1'b0);
        chk("swi_rd", 16'h0000, swi_rd);
        issue(PSW_CMD_VECTOR, 16'h0000, 3'h0);
        chk("vec_prev", 16'h3000, psw);
        issue(PSW_CMD_RETURN, 16'h4005, 3'h0);
        chk("return", 16'h7005, psw);
        chk("prev", 16'h0003, prev_m);
        issue(PSW_CMD_VECTOR, 16'h0000, 3'h0);
        @(posedge clk);
        dk <= 1'b0;
        issue(PSW_CMD_WRITE, 16'h00e0, 3'h0);
        chk("nokdata", 16'h1000, psw);
        @(posedge clk);
        dk <= 1'b1;
        $display("test modes done");
    endtask
    task automatic t_ints;
        // Request bit for level L sits at data bit 8+L
        pulse(16'h0800, 8'h00, 1'b0);
        chk("swi_lvl", 16'h0003, ilvl);
        chk("swi_rd_lvl", 16'h0866, swi_rd);
        chk("swi_vec", SWI_VECTOR, ivec);
        chk("swi_flag", 16'h0001, swi);
        issue(PSW_CMD_SPL, 16'h0000, 3'h3);
        chk("blocked", 16'h0000, pend);
        issue(PSW_CMD_SPL, 16'h0000, 3'h2);
        chk("open", 16'h0001, pend);
        pulse(16'h0000, 8'h40, 1'b1);
        chk("dev_lvl", 16'h0006, ilvl);
        chk("dev_vec", 16'h0118, ivec);
        issue(PSW_CMD_VECTOR, 16'h00c0, 3'h0);
        chk("nest_blk", 16'h0000, pend);
        pulse(16'h0000, 8'h80, 1'b0);
        chk("nest_lvl", 16'h0007, ilvl);
        pulse(16'h0000, 8'h00, 1'b1);
        chk("nest_ack", 16'h0000, pend);
        issue(PSW_CMD_RETURN, 16'h1040, 3'h0);
        chk("resume", 16'h0006, ilvl);
        $display("test ints done");
    endtask
    initial begin
        repeat (2000) @(posedge clk);
        error_cnt++;
        stop_test();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        #1;
        t_write();
        t_modes();
        t_ints();
        stop_test();
    end
endmodule
`default_nettype wire
